// *** shared/cif_pkg.sv ***
// What this block does
// - Eight-bit condition register, mask plus four flags
// - Add instructions set half carry from bit three
// - Mask bit set on entry or instruction
// - Masked requests stay latched until mask clears
// - Unmasking inside a handler services pending requests
// - Negative flag copies result bit seven
// - Zero flag set when result is zero
// - Carry from arithmetic, set/reset, test, shift, rotate
// - Reset leaves all maskable interrupts disabled
// - Entry finishes instruction, stacks, masks, then vectors
// - Return restores stacked register, mask bit taken from the stacked value
// - Simultaneous requests resolved by fixed priority
// - Any request wakes wait; chosen ones wake halt
// - Trap is taken whatever the mask
// - External vector only when occurred and unmasked
// - Edge requests latched, cleared on handler entry
// - External polarity comes from programmable sensitivity
// - Low enabled port pin masks combined source
// - Peripheral request needs mask clear and enable
// - Peripheral clear sequence drops its pending latch
package cif_pkg;

  // Bit positions inside the condition register
  localparam int unsigned CC_C_BIT = 0;
  localparam int unsigned CC_Z_BIT = 1;
  localparam int unsigned CC_N_BIT = 2;
  localparam int unsigned CC_I_BIT = 3;
  localparam int unsigned CC_H_BIT = 4;

  // Reset value and the bits forced to one
  localparam logic [7:0] CC_RESET_VALUE = 8'hE8;
  localparam logic [7:0] CC_FORCED_ONES = 8'hE0;

  // Width of a granted source index
  localparam int unsigned GRANT_W = 5;

  // Flag-affecting operations reported by the sequencer
  typedef enum logic [2:0] {
    OP_NONE                    = 3'b000,
    OP_ADD                     = 3'b001,
    OP_ARITH                   = 3'b010,
    OP_LOGIC                   = 3'b011,
    OP_SHIFT                   = 3'b100,
    OP_BIT_TEST                = 3'b101,
    OP_SET_CARRY_INSTRUCTION   = 3'b110,
    OP_RESET_CARRY_INSTRUCTION = 3'b111
  } cif_op_type;

  // One operation with operands and result
  typedef struct packed {
    cif_op_type op;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
  } cif_alu_type;

  // External sensitivity encoding
  typedef enum logic [1:0] {
    SENS_FALL_LOW = 2'b00,
    SENS_RISE     = 2'b01,
    SENS_FALL     = 2'b10,
    SENS_BOTH     = 2'b11
  } cif_sens_type;

  // Service state
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_SERVE = 1'b1
  } cif_state_type;

  // Service request payload
  typedef struct packed {
    logic               trap;
    logic [GRANT_W-1:0] index;
  } cif_grant_type;

endpackage : cif_pkg

// *** design/cif_core.sv ***
`timescale 1ns/1ns
module cif_core import cif_pkg::*; #(
  parameter int unsigned N_EXT         = 4,
  parameter int unsigned N_PORT        = 8,
  parameter int unsigned N_PER         = 8,
  parameter logic [7:0]  PER_HALT_WAKE = 8'h01
) (
  // Clock, reset, enable
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  input  wire logic                 i_clk_en,
  // Instruction sequencer
  input  wire logic                 i_boundary,
  input  wire cif_alu_type          i_alu,
  input  wire logic                 i_mask_instruction,
  input  wire logic                 i_unmask_instruction,
  input  wire logic                 i_trap_instruction,
  input  wire logic                 i_cc_restore,
  input  wire logic [7:0]           i_cc_data,
  input  wire logic                 i_service_ack,
  // External pins and sensitivity
  input  wire logic [N_EXT-1:0]     i_ext_pin,
  input  wire logic [2*N_EXT+1:0]   i_ext_sens,
  input  wire logic [N_PORT-1:0]    i_port_pin,
  input  wire logic [N_PORT-1:0]    i_port_irq_en,
  // Peripheral sources
  input  wire logic [N_PER-1:0]     i_periph_flag,
  input  wire logic [N_PER-1:0]     i_periph_en,
  input  wire logic [N_PER-1:0]     i_periph_clr,
  // Low power modes
  input  wire logic                 i_wait_mode,
  input  wire logic                 i_halt_mode,
  // Outputs
  output logic [7:0]                o_cc,
  output logic                      o_service_req,
  output cif_grant_type             o_grant,
  output logic                      o_wake
);

  // Line 0 is the combined port source, then the pins
  localparam int unsigned N_LINE = N_EXT + 1;
  localparam int unsigned N_SRC  = N_LINE + N_PER;
  localparam int unsigned N_SYNC = N_EXT + N_PORT;

  // Lowest set index wins
  function automatic logic [GRANT_W-1:0] first_set(input logic [N_SRC-1:0] v);
    logic [GRANT_W-1:0] r;
    r = '0;
    for (int k = N_SRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = GRANT_W'(k);
      end
    end
    return r;
  endfunction : first_set

  // Edge match for one sensitivity setting
  function automatic logic edge_hit(input logic [1:0] s, input logic p, input logic c);
    logic h;
    h = 1'b0;
    case (cif_sens_type'(s))
      SENS_RISE:     h = ~p & c;
      SENS_FALL:     h = p & ~c;
      SENS_FALL_LOW: h = p & ~c;
      SENS_BOTH:     h = p ^ c;
      default:       h = 1'b0;
    endcase
    return h;
  endfunction : edge_hit

  // Half carry out of the low nibble
  function automatic logic half_of(input cif_alu_type a);
    logic [4:0] s;
    s = {1'b0, a.operand_a[3:0]} + {1'b0, a.operand_b[3:0]} + {4'h0, a.carry_in};
    return s[4];
  endfunction : half_of

  cif_state_type    state;       // Service state
  logic [7:0]       cc;          // Condition register
  logic [N_SYNC-1:0] sync1;      // First synchroniser stage
  logic [N_SYNC-1:0] sync2;      // Second synchroniser stage
  logic [2:0]       primed;      // Stages holding real pin values
  logic [N_LINE-1:0] line_prev;  // Previous line levels
  logic [N_LINE-1:0] ext_latch;  // Latched edge requests
  logic [N_PER-1:0] flag_prev;   // Previous peripheral flags
  logic [N_PER-1:0] per_latch;   // Peripheral pending latches
  logic             trap_pend;   // Trap waiting for boundary
  logic [N_LINE-1:0] line_cur;   // Current line levels
  logic [N_LINE-1:0] ext_req;    // External requests
  logic [N_SRC-1:0] req_vec;     // Serviceable requests
  logic [N_SRC-1:0] halt_mask;   // Sources able to leave halt
  logic             take_entry;  // Handler entry this cycle
  logic             grant_ext;   // Granted source is external

  // Pin synchroniser; primed tracks when its reset zeros have drained
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1  <= '0;
      sync2  <= '0;
      primed <= 3'h0;
    end else if (i_clk_en) begin
      sync1  <= {i_port_pin, i_ext_pin};
      sync2  <= sync1;
      primed <= {primed[1:0], 1'b1};
    end
  end

  // Combined source low while any enabled port pin is low
  always_comb begin
    line_cur    = '0;
    line_cur[0] = &(sync2[N_SYNC-1:N_EXT] | ~i_port_irq_en);
    line_cur[N_LINE-1:1] = sync2[N_EXT-1:0];
  end

  assign take_entry = (state == ST_SERVE) && i_service_ack;
  assign grant_ext  = !o_grant.trap && (o_grant.index < GRANT_W'(N_LINE));

  // Edge latches, set beats clear on entry
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      line_prev <= '1;
      ext_latch <= '0;
    end else if (i_clk_en) begin
      line_prev <= line_cur;
      for (int k = 0; k < N_LINE; k++) begin
        // No edges until both compared levels come from real pins
        if (primed[2] && edge_hit(i_ext_sens[2*k +: 2], line_prev[k], line_cur[k])) begin
          ext_latch[k] <= 1'b1;
        end else if (take_entry && grant_ext && o_grant.index == GRANT_W'(k)) begin
          ext_latch[k] <= 1'b0;
        end
      end
    end
  end

  // Edge latch or live low level
  always_comb begin
    for (int k = 0; k < N_LINE; k++) begin
      ext_req[k] = ext_latch[k] |
        ((cif_sens_type'(i_ext_sens[2*k +: 2]) == SENS_FALL_LOW) & ~line_cur[k] & primed[1]);
    end
  end

  // Peripheral latches, new flag beats clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_prev <= '0;
      per_latch <= '0;
    end else if (i_clk_en) begin
      flag_prev <= i_periph_flag;
      per_latch <= (per_latch & ~i_periph_clr) | (i_periph_flag & ~flag_prev);
    end
  end

  // Enabled requests; latch stays even when disabled
  assign req_vec   = {per_latch & i_periph_en, ext_req};
  assign halt_mask = {PER_HALT_WAKE[N_PER-1:0], {N_LINE{1'b1}}};

  // Trap request held until entry
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      trap_pend <= 1'b0;
    end else if (i_clk_en) begin
      if (i_trap_instruction) begin
        trap_pend <= 1'b1;
      end else if (take_entry && o_grant.trap) begin
        trap_pend <= 1'b0;
      end
    end
  end

  // Grant at a boundary, hold until acknowledged
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state         <= ST_RUN;
      o_service_req <= 1'b0;
      o_grant       <= '0;
    end else if (i_clk_en) begin
      case (state)
        ST_RUN: begin
          if (i_boundary && trap_pend) begin
            state         <= ST_SERVE;
            o_service_req <= 1'b1;
            o_grant       <= '{trap: 1'b1, index: '0};
          end else if (i_boundary && !cc[CC_I_BIT] && |req_vec) begin
            state         <= ST_SERVE;
            o_service_req <= 1'b1;
            o_grant       <= '{trap: 1'b0, index: first_set(req_vec)};
          end
        end
        ST_SERVE: begin
          if (i_service_ack) begin
            state         <= ST_RUN;
            o_service_req <= 1'b0;
          end
        end
        default: begin
          state         <= ST_RUN;
          o_service_req <= 1'b0;
        end
      endcase
    end
  end

  // Condition register: restore, mask, flags
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cc <= CC_RESET_VALUE;
    end else if (i_clk_en) begin
      if (i_cc_restore) begin
        cc <= i_cc_data | CC_FORCED_ONES;
      end else begin
        // Entry beats an unmask in the same cycle
        if (take_entry || i_mask_instruction) begin
          cc[CC_I_BIT] <= 1'b1;
        end else if (i_unmask_instruction) begin
          cc[CC_I_BIT] <= 1'b0;
        end
        case (i_alu.op)
          OP_ADD: begin
            cc[CC_H_BIT] <= half_of(i_alu);
            cc[CC_C_BIT] <= i_alu.carry_out;
            cc[CC_N_BIT] <= i_alu.result[7];
            cc[CC_Z_BIT] <= (i_alu.result == 8'h00);
          end
          OP_ARITH, OP_SHIFT: begin
            cc[CC_C_BIT] <= i_alu.carry_out;
            cc[CC_N_BIT] <= i_alu.result[7];
            cc[CC_Z_BIT] <= (i_alu.result == 8'h00);
          end
          OP_LOGIC: begin
            cc[CC_N_BIT] <= i_alu.result[7];
            cc[CC_Z_BIT] <= (i_alu.result == 8'h00);
          end
          OP_BIT_TEST:                cc[CC_C_BIT] <= i_alu.carry_out;
          OP_SET_CARRY_INSTRUCTION:   cc[CC_C_BIT] <= 1'b1;
          OP_RESET_CARRY_INSTRUCTION: cc[CC_C_BIT] <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  assign o_cc = cc;

  // Wake: any request for wait, chosen ones for halt
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wake <= 1'b0;
    end else if (i_clk_en) begin
      o_wake <= (i_wait_mode && (|req_vec || trap_pend)) ||
                (i_halt_mode && |(req_vec & halt_mask));
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_upper_ones: assert property (o_cc[7:5] == 3'b111)
    else $error("upper condition bits not one");

  a_entry_masks: assert property (
    i_clk_en && take_entry && !i_cc_restore |=> o_cc[CC_I_BIT] && !o_service_req)
    else $error("entry did not set mask");

  a_masked_no_grant: assert property (
    i_clk_en && state == ST_RUN && o_cc[CC_I_BIT] && !trap_pend |=> !o_service_req)
    else $error("grant while masked");

  a_trap_any_mask: assert property (
    i_clk_en && state == ST_RUN && i_boundary && trap_pend |=> o_service_req && o_grant.trap)
    else $error("trap not taken");

  a_grant_lowest: assert property (
    $rose(o_service_req) && !o_grant.trap |-> o_grant.index == first_set($past(req_vec)))
    else $error("grant not highest priority");

  a_flag_result: assert property (
    i_clk_en && !i_cc_restore && (i_alu.op inside {OP_ADD, OP_ARITH, OP_LOGIC, OP_SHIFT})
    |=> o_cc[CC_Z_BIT] == ($past(i_alu.result) == 8'h00)
        && o_cc[CC_N_BIT] == $past(i_alu.result[7]))
    else $error("zero or negative flag wrong");

  a_half_carry: assert property (
    i_clk_en && !i_cc_restore && i_alu.op == OP_ADD |=> o_cc[CC_H_BIT] == $past(half_of(i_alu)))
    else $error("half carry wrong");

  a_latch_holds: assert property (
    i_clk_en && i_periph_clr == '0 |=> (per_latch & $past(per_latch)) == $past(per_latch))
    else $error("pending request lost");

  a_set_carry: assert property (
    i_clk_en && !i_cc_restore && i_alu.op == OP_SET_CARRY_INSTRUCTION |=> o_cc[CC_C_BIT])
    else $error("carry not set");

  c_trap_entry: cover property (take_entry && o_grant.trap);
  c_ext_entry: cover property (take_entry && grant_ext);
  c_nested_unmask: cover property (o_cc[CC_I_BIT] && i_unmask_instruction ##[1:20] $rose(o_service_req));
  c_halt_wake: cover property (i_halt_mode && o_wake);

endmodule : cif_core

// *** tb/cif_seq_model.sv ***
`timescale 1ns/1ns
module cif_seq_model (
  // Clock and speed select
  input  wire logic i_clock,
  input  wire logic i_slow,
  // Service handshake
  input  wire logic i_service_req,
  output logic      o_service_ack
);
  int cnt  = 0; // Cycles spent stacking
  int hold = 0; // Settle time after an ack

  // Stack, then acknowledge for one cycle; slow mode stalls longer
  always @(negedge i_clock) begin
    if (hold > 0) begin
      o_service_ack <= 1'b0;
      hold          <= hold - 1;
    end else if (i_service_req === 1'b1 && cnt >= (i_slow ? 4 : 0)) begin
      o_service_ack <= 1'b1;
      cnt           <= 0;
      hold          <= 2;
    end else begin
      o_service_ack <= 1'b0;
      if (i_service_req === 1'b1) begin
        cnt <= cnt + 1;
      end
    end
  end
  initial o_service_ack = 1'b0;
endmodule : cif_seq_model

// *** tb/cpu_interrupt_and_flags_tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module cpu_interrupt_and_flags_tb import cif_pkg::*; ;
  logic          i_clock = 0, i_resetn = 0, slow = 0, ack;
  logic          bnd = 0, msk = 0, umsk = 0, trp = 0, rst = 0, wt = 0;
  cif_alu_type   alu = '0;  // Operation under test
  logic [7:0]    d = 0, cc_m = 8'hE8, pflag = 0, pen = 0, pclr = 0, o_cc;
  logic [3:0]    ext = 4'hF; // External lines idle high
  logic [7:0]    pport = 8'hFF, pirq = 8'h00; // Port pins and their enables
  logic [9:0]    sens = 10'h004; // Line 0 fall+low, line 1 rising
  logic          en = 1'b1, hlt = 1'b0; // Clock enable and halt mode
  logic          req, wake;
  cif_grant_type grant;
  int            miscompares = 0, check_count = 0;

  // Clock at 100 ns
  always #50 i_clock = ~i_clock;

  cif_core i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(en),
    .i_boundary(bnd), .i_alu(alu), .i_mask_instruction(msk),
    .i_unmask_instruction(umsk), .i_trap_instruction(trp), .i_cc_restore(rst),
    .i_cc_data(d), .i_service_ack(ack), .i_ext_pin(ext), .i_ext_sens(sens),
    .i_port_pin(pport), .i_port_irq_en(pirq), .i_periph_flag(pflag),
    .i_periph_en(pen), .i_periph_clr(pclr), .i_wait_mode(wt), .i_halt_mode(hlt),
    .o_cc(o_cc), .o_service_req(req), .o_grant(grant), .o_wake(wake));

  cif_seq_model i_seq (.i_clock(i_clock), .i_slow(slow), .i_service_req(req),
    .o_service_ack(ack));

  task tick;
    @(negedge i_clock);
  endtask : tick

  task summarize;
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // One flag-affecting operation, model updated alongside
  task alu_op(input cif_op_type op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    alu = '{op: op, operand_a: a, operand_b: b, carry_in: 1'b0, result: r[7:0],
            carry_out: r[8]};
    tick;
    alu.op = OP_NONE;
    tick;
    if (op == OP_ADD) cc_m[4:0] = {h[4], cc_m[3], r[7], r[7:0] == 8'h00, r[8]};
    else cc_m[0] = (op == OP_SET_CARRY_INSTRUCTION);
    `CHK(o_cc, cc_m)
  endtask : alu_op

  // Mask, unmask and trap pulses
  task ctl(input logic m, input logic u, input logic t);
    {msk, umsk, trp} = {m, u, t};
    tick;
    {msk, umsk, trp} = 3'b000;
    tick;
    if (m) cc_m[3] = 1'b1;
    if (u) cc_m[3] = 1'b0;
  endtask : ctl

  // Boundary expected to grant, then wait for the stacking handshake
  task serve(input logic tr, input logic [4:0] idx);
    int n;
    slow = 1'($urandom);
    bnd  = 1'b1;
    tick;
    bnd  = 1'b0;
    `CHK(req, 1'b1)
    `CHK(grant, cif_grant_type'({tr, idx}))
    n = 0;
    while (req === 1'b1 && n < 20) begin
      tick;
      n++;
    end
    if (req === 1'b1) begin
      miscompares++;
      $display("ERROR %0t: service never acknowledged", $time);
      summarize;
    end
    cc_m[3] = 1'b1;
    `CHK(o_cc, cc_m)
  endtask : serve

  // Boundary expected to be refused
  task none;
    bnd = 1'b1;
    tick;
    bnd = 1'b0;
    `CHK(req, 1'b0)
  endtask : none

  // Main sequence
  initial begin
    void'($urandom(32'hc217));
    repeat (8) tick;
    i_resetn = 1'b1;
    `CHK(o_cc, 8'hE8)
    `CHK(req, 1'b0)
    repeat (8) alu_op(OP_ADD, 8'($urandom), 8'($urandom));
    alu_op(OP_ADD, 8'h08, 8'h08);
    alu_op(OP_ADD, 8'h80, 8'h80);
    alu_op(OP_SET_CARRY_INSTRUCTION, 8'h00, 8'h00);
    alu_op(OP_RESET_CARRY_INSTRUCTION, 8'h00, 8'h00);
    // Restore forces upper bits, leaves the mask set
    d   = 8'($urandom) | 8'h08;
    rst = 1'b1;
    tick;
    rst = 1'b0;
    tick;
    cc_m = d | 8'hE0;
    `CHK(o_cc, cc_m)
    ctl(1'b0, 1'b0, 1'b1);
    serve(1'b1, 5'd0);
    // Two peripherals latched under mask, taken by priority
    pen   = 8'h24;
    pflag = 8'h24;
    tick;
    none();
    ctl(1'b0, 1'b1, 1'b0);
    serve(1'b0, 5'd7);
    pclr = 8'h04;
    tick;
    pclr = 8'h00;
    ctl(1'b0, 1'b1, 1'b0);
    serve(1'b0, 5'd10);
    pclr  = 8'h20;
    pflag = 8'h00;
    tick;
    // Unenabled pending request lost by the clear sequence
    pen   = 8'h00;
    pclr  = 8'h00;
    pflag = 8'h08;
    tick;
    pclr  = 8'h08;
    tick;
    pclr  = 8'h00;
    pen   = 8'h08;
    ctl(1'b0, 1'b1, 1'b0);
    none();
    // Request wakes the wait mode
    wt    = 1'b1;
    pen   = 8'h0A;
    pflag = 8'h0A;
    repeat (3) tick;
    `CHK(wake, 1'b1)
    wt = 1'b0;
    serve(1'b0, 5'd6);
    pclr = 8'h02;
    tick;
    pclr = 8'h00;
    // External rising edge latched under mask, cleared on entry
    ext[0] = 1'b0;
    repeat (3) tick;
    ext[0] = 1'b1;
    repeat (4) tick;
    ctl(1'b0, 1'b1, 1'b0);
    serve(1'b0, 5'd1);
    ctl(1'b0, 1'b1, 1'b0);
    none();
    // Low enabled port pin holds the rising-edge combined source down
    sens  = 10'h005;
    pirq  = 8'h03;
    pport = 8'hFC;
    repeat (4) tick;
    pport = 8'hFD;
    repeat (4) tick;
    none();
    pport = 8'hFF;
    repeat (4) tick;
    serve(1'b0, 5'd0);
    ctl(1'b1, 1'b0, 1'b0);
    `CHK(o_cc, cc_m)
    // Halt left only by designated sources
    hlt   = 1'b1;
    pflag = 8'h08;
    tick;
    pflag = 8'h0A;
    repeat (3) tick;
    `CHK(wake, 1'b0)
    pen   = 8'h0B;
    pflag = 8'h0B;
    repeat (3) tick;
    `CHK(wake, 1'b1)
    hlt = 1'b0;
    // Clock enable low freezes the mask against an unmask pulse
    en   = 1'b0;
    umsk = 1'b1;
    tick;
    umsk = 1'b0;
    en   = 1'b1;
    tick;
    `CHK(o_cc, cc_m)
    summarize();
  end
endmodule : cpu_interrupt_and_flags_tb
